//--- core/bdma_addr_core.sv
// Banked data memory address former for an 8-bit core.
// Assumes the core's decode logic drives operand, strobes and the phase.
//
// Overview of operation
// - Twelve-bit address, sixteen banks of 256 bytes.
// - Unimplemented locations read as zeros.
// - Bank pointer keeps low four bits only.
// - Load-bank instruction loads pointer from literal.
// - Banked address is pointer over operand.
// - Unimplemented bank: drop writes, flags still update.
// - Full-address move ignores the bank pointer.
// - Fast window: 00-5F bank 0, 60-FF bank 15.
// - Access bit one banked, zero fast window.
// - Fast accesses need no prior pointer update.
// - Extended set uses modified fast mapping.
// - General storage is never reset.
// - General area low, special area at top.
// - Flag-affecting status writes update only flags.
// - Bit, swap, move ops write status directly.
// - Carry flags act as active-low borrows.
// - Read in second quarter, write in fourth.
`timescale 1ns/1ps
`default_nettype none
module bdma_addr_core (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [1:0] quarter,
	input  wire logic [7:0] operand,
	input  wire logic       accessBanked,
	input  wire logic       fullMove,
	input  wire logic [11:0] fullAddr,
	input  wire logic       rdReq,
	input  wire logic       wrReq,
	input  wire logic [7:0] wrData,
	input  wire logic       loadBankLiteral,
	input  wire logic [7:0] bankLiteral,
	input  wire logic       extendedIsaEnable,
	input  wire logic       flagsAffected,
	input  wire logic [4:0] aluFlags,
	output logic      [7:0] rdData,
	output logic      [11:0] effAddr,
	output logic      [7:0] bankPointer,
	output logic      [7:0] status
);

	bdma_mem_if memBus ();

	logic [3:0]  bankReg;
	logic [3:0]  next_bankReg;
	logic [7:0]  next_rdData;
	logic [7:0]  fastSplit;
	logic        readPhase;
	logic        writePhase;
	logic        hitPtr;
	logic        hitStatus;
	logic [7:0]  ptrRead;

	// ----------------------------------------------------------------
	// Address formation
	// ----------------------------------------------------------------
	function automatic logic [11:0] form_addr(
		input logic [3:0]  bank,
		input logic [7:0]  ofs,
		input logic        banked,
		input logic        full,
		input logic [11:0] fAddr,
		input logic [7:0]  split
	);
		logic [11:0] a;
		a = {bank, ofs};
		if (full) begin
			a = fAddr;
		end else if (!banked) begin
			if (ofs < split) begin
				a = {bdma_pkg::FAST_LO_BANK, ofs};
			end else begin
				a = {bdma_pkg::FAST_HI_BANK, ofs};
			end
		end
		return a;
	endfunction : form_addr

	always_comb begin
		// The extended set moves the split upward.
		fastSplit = extendedIsaEnable ? bdma_pkg::XFAST_SPLIT
			: bdma_pkg::FAST_SPLIT;
		effAddr = form_addr(bankReg, operand, accessBanked, fullMove,
			fullAddr, fastSplit);
		readPhase  = quarter == bdma_pkg::PHASE_READ;
		writePhase = quarter == bdma_pkg::PHASE_WRITE;
		hitPtr    = effAddr == bdma_pkg::BANK_PTR_ADDR;
		hitStatus = effAddr == bdma_pkg::STATUS_ADDR;
		ptrRead   = {4'h0, bankReg};
	end

	assign memBus.addr   = effAddr;
	assign memBus.rdEn   = readPhase && rdReq;
	// Writes outside implemented areas are dropped by the store.
	assign memBus.wrEn   = writePhase && wrReq && !hitPtr && !hitStatus;
	assign memBus.wrData = wrData;

	bdma_store store (
		.clk (clk),
		.mem (memBus)
	);

	// Flag-affecting instructions move the flags whatever the destination,
	// so a write dropped in an unimplemented bank still updates them.
	bdma_status statusReg (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.wrPhase       (writePhase),
		.regWrite      (wrReq && hitStatus),
		.wrData        (wrData),
		.flagsAffected (flagsAffected),
		.aluFlags      (aluFlags),
		.status        (status)
	);

	// ----------------------------------------------------------------
	// Bank pointer
	// ----------------------------------------------------------------
	always_comb begin
		next_bankReg = bankReg;
		if (writePhase && loadBankLiteral) begin
			next_bankReg = bankLiteral[3:0];
		end else if (writePhase && wrReq && hitPtr) begin
			next_bankReg = wrData[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bankReg <= 4'h0;
		end else begin
			bankReg <= next_bankReg;
		end
	end

	assign bankPointer = ptrRead;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		next_rdData = rdData;
		if (readPhase && rdReq) begin
			if (hitPtr) begin
				next_rdData = ptrRead;
			end else if (hitStatus) begin
				next_rdData = status;
			end else if (memBus.hit) begin
				next_rdData = memBus.rdData;
			end else begin
				next_rdData = 8'h00;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdData <= 8'h00;
		end else begin
			rdData <= next_rdData;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_ptr_upper_zero : assert property (
		@(posedge clk) disable iff (sys_rst)
		bankPointer[7:4] == 4'h0)
		else $error("bank pointer upper bits not zero");
	a_banked_addr : assert property (
		@(posedge clk) disable iff (sys_rst)
		accessBanked && !fullMove |-> effAddr == {bankReg, operand})
		else $error("banked address wrong");
	a_full_addr : assert property (
		@(posedge clk) disable iff (sys_rst)
		fullMove |-> effAddr == fullAddr)
		else $error("full move address wrong");
	a_fast_lo_map : assert property (
		@(posedge clk) disable iff (sys_rst)
		!accessBanked && !fullMove && !extendedIsaEnable && operand < 8'h60
		|-> effAddr[11:8] == 4'h0)
		else $error("fast low map wrong");
	a_fast_hi_map : assert property (
		@(posedge clk) disable iff (sys_rst)
		!accessBanked && !fullMove && operand >= 8'h80
		|-> effAddr[11:8] == 4'hf)
		else $error("fast high map wrong");
	a_ext_fast_split : assert property (
		@(posedge clk) disable iff (sys_rst)
		!accessBanked && !fullMove && extendedIsaEnable && operand == 8'h70
		|-> effAddr[11:8] == 4'h0)
		else $error("extended fast map wrong");
	a_fast_offset : assert property (
		@(posedge clk) disable iff (sys_rst)
		!accessBanked && !fullMove |-> effAddr[7:0] == operand)
		else $error("fast window offset wrong");
	a_unimpl_read_zero : assert property (
		@(posedge clk) disable iff (sys_rst)
		readPhase && rdReq && !memBus.hit && !hitPtr && !hitStatus
		|=> rdData == 8'h00)
		else $error("unimplemented read not zero");
	a_literal_load : assert property (
		@(posedge clk) disable iff (sys_rst)
		writePhase && loadBankLiteral |=> bankReg == $past(bankLiteral[3:0]))
		else $error("load bank literal failed");
	a_ptr_hold : assert property (
		@(posedge clk) disable iff (sys_rst)
		!writePhase |=> bankReg == $past(bankReg))
		else $error("bank pointer changed outside a write");
	a_ptr_write_mask : assert property (
		@(posedge clk) disable iff (sys_rst)
		writePhase && wrReq && hitPtr && !loadBankLiteral
		|=> bankPointer == ($past(wrData) & bdma_pkg::BANK_PTR_MASK))
		else $error("bank pointer write not masked");
	a_ptr_read_data : assert property (
		@(posedge clk) disable iff (sys_rst)
		readPhase && rdReq && hitPtr |=> rdData == {4'h0, $past(bankReg)})
		else $error("bank pointer read wrong");
	a_status_read : assert property (
		@(posedge clk) disable iff (sys_rst)
		readPhase && rdReq && hitStatus |=> rdData == $past(status))
		else $error("status read wrong");
	a_write_phase_only : assert property (
		@(posedge clk) disable iff (sys_rst)
		memBus.wrEn |-> quarter == 2'h3)
		else $error("write outside fourth quarter");
	a_rd_data_hold : assert property (
		@(posedge clk) disable iff (sys_rst)
		!(readPhase && rdReq) |=> rdData == $past(rdData))
		else $error("read data changed outside second quarter");
	a_reset_bank : assert property (
		@(posedge clk)
		sys_rst |=> bankReg == 4'h0)
		else $error("bank pointer not cleared by reset");
	a_unimpl_no_write : assert property (
		@(posedge clk) disable iff (sys_rst)
		memBus.wrEn && !memBus.hit |=> rdData == $past(rdData))
		else $error("unimplemented write had an effect");
	a_flags_any_dest : assert property (
		@(posedge clk) disable iff (sys_rst)
		writePhase && flagsAffected && !hitStatus
		|=> status[4:0] == $past(aluFlags))
		else $error("flags not updated for another destination");

	c_banked_read : cover property (@(posedge clk)
		readPhase && rdReq && accessBanked && memBus.hit);
	c_fast_write : cover property (@(posedge clk)
		memBus.wrEn && !accessBanked);
	c_full_move : cover property (@(posedge clk) memBus.wrEn && fullMove);
	c_status_quirk : cover property (@(posedge clk)
		writePhase && flagsAffected && hitStatus);
	c_literal_load : cover property (@(posedge clk)
		writePhase && loadBankLiteral);

endmodule : bdma_addr_core
`default_nettype wire

//--- core/bdma_mem_if.sv
// Interface between the address former and the storage array.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface bdma_mem_if;
	logic [11:0] addr;
	logic        rdEn;
	logic        wrEn;
	logic [7:0]  wrData;
	logic [7:0]  rdData;
	logic        hit;

	modport ctl (output addr, output rdEn, output wrEn, output wrData,
		input rdData, input hit);
	modport mem (input addr, input rdEn, input wrEn, input wrData,
		output rdData, output hit);
endinterface : bdma_mem_if
`default_nettype wire

//--- core/bdma_pkg.sv
// Constants and types for the banked data memory addressing block.
// Assumes one core clock and a quarter-cycle phase supplied by the core.
package bdma_pkg;

	// ----------------------------------------------------------------
	// Address space
	// ----------------------------------------------------------------
	localparam int          ADDR_W       = 12;
	localparam int          BANK_W       = 4;
	localparam int          OFS_W        = 8;
	localparam int          DATA_W       = 8;
	localparam int          BANK_COUNT   = 16;
	localparam int          BANK_BYTES   = 256;
	localparam int          MEM_BYTES    = 4096;

	// ----------------------------------------------------------------
	// Fast-access window split and implemented areas
	// ----------------------------------------------------------------
	localparam logic [7:0]  FAST_SPLIT   = 8'h60;
	localparam logic [3:0]  FAST_LO_BANK = 4'h0;
	localparam logic [3:0]  FAST_HI_BANK = 4'hf;
	localparam logic [7:0]  XFAST_SPLIT  = 8'h80;
	localparam logic [11:0] GPA_TOP      = 12'h5ff;
	localparam logic [11:0] SFA_BASE     = 12'hf60;
	localparam int          GPA_DEPTH    = 1536;
	localparam int          SFA_DEPTH    = 160;

	// ----------------------------------------------------------------
	// Special function locations held here
	// ----------------------------------------------------------------
	localparam logic [11:0] BANK_PTR_ADDR = 12'hfe0;
	localparam logic [11:0] STATUS_ADDR   = 12'hfd8;
	localparam logic [7:0]  BANK_PTR_RST  = 8'h00;
	localparam logic [7:0]  STATUS_RST    = 8'h00;
	localparam logic [7:0]  BANK_PTR_MASK = 8'h0f;

	// ----------------------------------------------------------------
	// Status flag positions
	// ----------------------------------------------------------------
	localparam int          FLAG_C  = 0;
	localparam int          FLAG_HC = 1;
	localparam int          FLAG_Z  = 2;
	localparam int          FLAG_SE = 3;
	localparam int          FLAG_N  = 4;
	localparam logic [7:0]  ARITH_MASK = 8'h1f;

	// ----------------------------------------------------------------
	// Quarter phases of one instruction cycle
	// ----------------------------------------------------------------
	localparam logic [1:0]  PHASE_READ  = 2'h1;
	localparam logic [1:0]  PHASE_WRITE = 2'h3;

	typedef enum logic [1:0] {
		BDMA_ADDR_BANKED,
		BDMA_ADDR_FAST,
		BDMA_ADDR_FULL
	} bdma_mode_t;

endpackage : bdma_pkg

//--- core/bdma_status.sv
// Status flag register with the destination-write quirk.
// Assumes the ALU supplies flags and an affects-flags indication.
`timescale 1ns/1ps
`default_nettype none
module bdma_status (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       wrPhase,
	input  wire logic       regWrite,
	input  wire logic [7:0] wrData,
	input  wire logic       flagsAffected,
	input  wire logic [4:0] aluFlags,
	output logic      [7:0] status
);

	logic [7:0] next_status;

	// ----------------------------------------------------------------
	// Next value
	// ----------------------------------------------------------------
	always_comb begin
		next_status = status;
		if (wrPhase && flagsAffected) begin
			// The computed byte is dropped; only affected flags move.
			next_status = (status & ~bdma_pkg::ARITH_MASK)
				| {3'h0, aluFlags};
		end else if (wrPhase && regWrite) begin
			next_status = wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status <= bdma_pkg::STATUS_RST;
		end else begin
			status <= next_status;
		end
	end

	a_flag_only_update : assert property (
		@(posedge clk) disable iff (sys_rst)
		wrPhase && flagsAffected |=> status[4:0] == $past(aluFlags))
		else $error("status flags not taken from the ALU");
	a_plain_status_write : assert property (
		@(posedge clk) disable iff (sys_rst)
		wrPhase && regWrite && !flagsAffected |=> status == $past(wrData))
		else $error("status write did not take effect as written");
	a_status_upper_hold : assert property (
		@(posedge clk) disable iff (sys_rst)
		flagsAffected |=> status[7:5] == $past(status[7:5]))
		else $error("status upper bits changed on flag update");

endmodule : bdma_status
`default_nettype wire

//--- core/bdma_store.sv
// Storage for the general purpose and special function areas.
// Assumes strobes arrive from the address former on the core clock.
`timescale 1ns/1ps
`default_nettype none
module bdma_store (
	input  wire logic clk,
	bdma_mem_if.mem   mem
);

	logic [7:0] gpa [bdma_pkg::GPA_DEPTH];
	logic [7:0] sfa [bdma_pkg::SFA_DEPTH];
	logic       inGpa;
	logic       inSfa;
	logic [10:0] gIdx;
	logic [7:0]  sIdx;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	always_comb begin
		inGpa = mem.addr <= bdma_pkg::GPA_TOP;
		inSfa = mem.addr >= bdma_pkg::SFA_BASE;
		gIdx  = mem.addr[10:0];
		sIdx  = 8'(mem.addr - bdma_pkg::SFA_BASE);
	end

	assign mem.hit = inGpa | inSfa;

	// Locations have no reset so their content survives every reset.
	always_ff @(posedge clk) begin
		if (mem.wrEn && inGpa) begin
			gpa[gIdx] <= mem.wrData;
		end
		if (mem.wrEn && inSfa) begin
			sfa[sIdx] <= mem.wrData;
		end
	end

	// Read data is only presented while the read strobe stands.
	always_comb begin
		if (mem.rdEn && inGpa) begin
			mem.rdData = gpa[gIdx];
		end else if (mem.rdEn && inSfa) begin
			mem.rdData = sfa[sIdx];
		end else begin
			mem.rdData = 8'h00;
		end
	end

endmodule : bdma_store
`default_nettype wire

//--- sim/banked_data_memory_addressing_test.sv
// Self-checking bench for the banked data memory address former.
// Assumes the design sources and the instruction model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_addressing_test;
	logic        clk;
	logic        sys_rst;
	logic        ext;
	logic [1:0]  quarter;
	logic [7:0]  operand, wrData, bankLiteral, rdData, bankPointer, status;
	logic        accessBanked, fullMove, rdReq, wrReq, loadBankLiteral;
	logic        flagsAffected;
	logic [4:0]  aluFlags;
	logic [11:0] fullAddr, effAddr;
	int          n_mismatch, n_checks, i;

	bdma_cpu_model cpu (.clk(clk), .rdData(rdData), .effAddr(effAddr),
		.quarter(quarter), .operand(operand), .accessBanked(accessBanked),
		.fullMove(fullMove), .fullAddr(fullAddr), .rdReq(rdReq),
		.wrReq(wrReq), .wrData(wrData), .loadBankLiteral(loadBankLiteral),
		.bankLiteral(bankLiteral), .flagsAffected(flagsAffected),
		.aluFlags(aluFlags));
	bdma_addr_core dut (.clk(clk), .sys_rst(sys_rst), .quarter(quarter),
		.operand(operand), .accessBanked(accessBanked), .fullMove(fullMove),
		.fullAddr(fullAddr), .rdReq(rdReq), .wrReq(wrReq), .wrData(wrData),
		.loadBankLiteral(loadBankLiteral), .bankLiteral(bankLiteral),
		.extendedIsaEnable(ext), .flagsAffected(flagsAffected),
		.aluFlags(aluFlags), .rdData(rdData), .effAddr(effAddr),
		.bankPointer(bankPointer), .status(status));

	always #25 clk = ~clk;

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic acc(input logic b, input logic [7:0] o, input logic w,
		input logic [7:0] d, input logic fl, input logic [4:0] af);
		cpu.op(b, o, 1'b0, 12'h000, !w, w, d, 1'b0, 8'h00, fl, af);
	endtask : acc

	task automatic mv(input logic [11:0] a, input logic w, input logic [7:0] d);
		cpu.op(1'b0, 8'h00, 1'b1, a, !w, w, d, 1'b0, 8'h00, 1'b0, 5'h00);
	endtask : mv

	task automatic bank(input logic [7:0] lit);
		cpu.op(1'b0, 8'h00, 1'b0, 12'h000, 1'b0, 1'b0, 8'h00, 1'b1, lit,
			1'b0, 5'h00);
	endtask : bank

	task automatic conclude;
		$display("Checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	initial begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		$display("Error at %0t: run did not finish", $time);
		conclude();
	end

	initial begin
		{clk, ext, n_mismatch, n_checks} = '0;
		sys_rst = 1'b1;
		repeat (4) @(posedge clk);
		#1 sys_rst = 1'b0;
		chk({4'h0, bankPointer}, 12'h000);
		chk({4'h0, status}, 12'h000);
		$display("Test reset state done");
		bank(8'hf3);
		chk({4'h0, bankPointer}, 12'h003);
		mv(bdma_pkg::BANK_PTR_ADDR, 1'b1, 8'hab);
		chk({4'h0, bankPointer}, 12'h00b);
		mv(bdma_pkg::BANK_PTR_ADDR, 1'b0, 8'h00);
		chk({4'h0, cpu.rdv}, 12'h00b);
		chk(cpu.seenAddr, 12'hfe0);
		$display("Test bank pointer done");
		for (i = 0; i < 6; i++) begin
			bank(8'(i));
			acc(1'b1, 8'h34, 1'b1, 8'(8'h50 + i), 1'b0, 5'h00);
			chk(cpu.seenAddr, {4'(i), 8'h34});
		end
		for (i = 0; i < 6; i++) begin
			mv({4'(i), 8'h34}, 1'b0, 8'h00);
			chk({4'h0, cpu.rdv}, {4'h0, 8'(8'h50 + i)});
		end
		$display("Test banked access done");
		acc(1'b0, 8'h34, 1'b0, 8'h00, 1'b0, 5'h00);
		chk({4'h0, cpu.rdv}, 12'h050);
		acc(1'b1, 8'h34, 1'b0, 8'h00, 1'b0, 5'h00);
		chk({4'h0, cpu.rdv}, 12'h055);
		acc(1'b0, 8'h5f, 1'b0, 8'h00, 1'b0, 5'h00);
		chk(cpu.seenAddr, 12'h05f);
		acc(1'b0, 8'h60, 1'b0, 8'h00, 1'b0, 5'h00);
		chk(cpu.seenAddr, 12'hf60);
		acc(1'b0, 8'hff, 1'b0, 8'h00, 1'b0, 5'h00);
		chk(cpu.seenAddr, 12'hfff);
		ext = 1'b1;
		acc(1'b0, 8'h70, 1'b0, 8'h00, 1'b0, 5'h00);
		chk(cpu.seenAddr, 12'h070);
		acc(1'b0, 8'h90, 1'b0, 8'h00, 1'b0, 5'h00);
		chk(cpu.seenAddr, 12'hf90);
		ext = 1'b0;
		$display("Test fast window done");
		bank(8'h07);
		acc(1'b1, 8'h20, 1'b1, 8'hff, 1'b1, 5'h05);
		chk({4'h0, status}, 12'h005);
		acc(1'b1, 8'h20, 1'b0, 8'h00, 1'b0, 5'h00);
		chk({4'h0, cpu.rdv}, 12'h000);
		mv(12'h5ff, 1'b1, 8'h3c);
		mv(12'h600, 1'b1, 8'hc3);
		mv(12'h5ff, 1'b0, 8'h00);
		chk({4'h0, cpu.rdv}, 12'h03c);
		mv(12'h600, 1'b0, 8'h00);
		chk({4'h0, cpu.rdv}, 12'h000);
		$display("Test unimplemented space done");
		acc(1'b0, bdma_pkg::STATUS_ADDR[7:0], 1'b1, 8'he3, 1'b0, 5'h00);
		chk({4'h0, status}, 12'h0e3);
		acc(1'b0, bdma_pkg::STATUS_ADDR[7:0], 1'b1, 8'h00, 1'b1, 5'h04);
		chk({4'h0, status}, 12'h0e4);
		$display("Test status write done");
		@(posedge clk);
		#1 sys_rst = 1'b1;
		repeat (4) @(posedge clk);
		#1 sys_rst = 1'b0;
		chk({4'h0, bankPointer}, 12'h000);
		mv(12'h034, 1'b0, 8'h00);
		chk({4'h0, cpu.rdv}, 12'h050);
		chk({4'h0, rdData}, 12'h050);
		$display("Test second reset done");
		conclude();
	end
endmodule : banked_data_memory_addressing_test
`default_nettype wire

//--- sim/bdma_cpu_model.sv
// Instruction decode and execute model that drives one instruction at a time.
// Assumes the core clock and the address former's read data and address.
`timescale 1ns/1ps
`default_nettype none
module bdma_cpu_model (
	input  wire logic        clk,
	input  wire logic [7:0]  rdData,
	input  wire logic [11:0] effAddr,
	output logic      [1:0]  quarter,
	output logic      [7:0]  operand,
	output logic             accessBanked,
	output logic             fullMove,
	output logic      [11:0] fullAddr,
	output logic             rdReq,
	output logic             wrReq,
	output logic      [7:0]  wrData,
	output logic             loadBankLiteral,
	output logic      [7:0]  bankLiteral,
	output logic             flagsAffected,
	output logic      [4:0]  aluFlags
);
	logic [7:0]  rdv;
	logic [11:0] seenAddr;

	initial begin
		{quarter, operand, accessBanked, fullMove, fullAddr} = '0;
		{rdReq, wrReq, wrData, loadBankLiteral, bankLiteral} = '0;
		{flagsAffected, aluFlags, rdv, seenAddr} = '0;
	end

	// ----------------------------------------------------------------
	// One instruction cycle
	// ----------------------------------------------------------------
	// Operand fields stand for the whole instruction; the strobes stand
	// only in their own quarter, and the data lines are turned over after.
	task automatic op(input logic b, input logic [7:0] o, input logic f,
		input logic [11:0] fa, input logic rd, input logic wr,
		input logic [7:0] wd, input logic lb, input logic [7:0] lit,
		input logic fl, input logic [4:0] af);
		int q;
		for (q = 0; q < 5; q++) begin
			@(posedge clk);
			#1;
			if (q == 2) begin
				rdv = rdData;
				seenAddr = effAddr;
			end
			quarter = 2'(q);
			{accessBanked, operand, fullMove, fullAddr} = {b, o, f, fa};
			{flagsAffected, aluFlags, bankLiteral} = {fl, af, lit};
			wrData = (q == 4) ? ~wd : wd;
			rdReq = rd & (q == 1);
			wrReq = wr & (q == 3);
			loadBankLiteral = lb & (q == 3);
		end
	endtask : op
endmodule : bdma_cpu_model
`default_nettype wire
